// file: tse_signaling.sv
/*
  T1/E1 signaling block: receive buffering, freeze, reinsertion and T1 force-ones,
  and transmit signaling insertion from host registers, behind an AHB-Lite slave.
  Assumes one 100 MHz clock; channel streams arrive one byte per valid strobe
  from framer logic on the same clock; only the multiframe sync pin is external.
*/
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`include "tse_params.svh"
`default_nettype none

module tse_signaling #(
  parameter int HOLD_ESF_CYC = `TSE_HOLD_ESF_US * `TSE_CLK_MHZ,
  parameter int HOLD_D4_CYC = `TSE_HOLD_D4_US * `TSE_CLK_MHZ
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rx_multiframe_sync_pin,
  input wire logic rx_line_mf,
  input wire logic rx_sig_wr,
  input wire logic [4:0] rx_sig_chan,
  input wire logic [3:0] rx_sig_nib,
  input wire logic rx_loss_of_frame,
  input wire logic rx_carrier_loss,
  input wire logic rx_frame_slip,
  input wire logic rx_chan_valid,
  input wire logic [4:0] rx_chan_idx,
  input wire logic [7:0] rx_chan_data,
  output logic [7:0] rx_serial_out,
  output logic rx_serial_valid,
  output logic [7:0] rx_signaling_out,
  output logic rx_freeze_indicator,
  input wire logic tx_mf_boundary,
  input wire logic tx_chan_valid,
  input wire logic [4:0] tx_chan_idx,
  input wire logic [4:0] tx_frame_num,
  input wire logic [7:0] tx_chan_data,
  output logic [7:0] tx_serial_out,
  output logic tx_serial_valid
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_rob(input logic [4:0] fr, input logic esf);
    is_rob = (fr == `TSE_ROB_A) || (fr == `TSE_ROB_B) ||
             (esf && ((fr == `TSE_ROB_C) || (fr == `TSE_ROB_D)));
  endfunction : is_rob

  // Picks A/B/C/D for the frame; use_cd maps D4 frames onto C and D
  function automatic logic sel_bit(input logic [3:0] nib, input logic [4:0] fr, input logic use_cd);
    if (fr == `TSE_ROB_A)
      sel_bit = use_cd ? nib[1] : nib[3];
    else if (fr == `TSE_ROB_B)
      sel_bit = use_cd ? nib[0] : nib[2];
    else if (fr == `TSE_ROB_C)
      sel_bit = nib[1];
    else
      sel_bit = nib[0];
  endfunction : sel_bit

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  tse_pkg::tse_byte_t sigctl_reg;
  tse_pkg::tse_byte_t pcptr_reg;
  tse_pkg::tse_byte_t t1txc_reg;
  tse_pkg::tse_byte_t e1txc_reg;
  tse_pkg::tse_byte_t stat4_reg;
  tse_pkg::tse_byte_t mode_reg;
  tse_pkg::tse_byte_t pcd_reg [4];
  tse_pkg::tse_byte_t ssie_reg [4];
  tse_pkg::tse_byte_t ts_reg [16];
  tse_pkg::tse_byte_t shadow_reg [16];
  tse_pkg::tse_frz_state_t frz_state_reg;
  tse_pkg::tse_frz_state_t frz_state_next;
  logic [19:0] hold_cnt_reg;
  logic [19:0] hold_cnt_next;
  logic wr_pend_reg;
  logic [4:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_s3_reg;
  logic [4:0] bp_frame_reg;
  logic d4_phase_reg;
  logic [7:0] rx_serial_out_reg;
  logic rx_serial_valid_reg;
  logic [7:0] rx_signaling_out_reg;
  logic rx_freeze_reg;
  logic [7:0] tx_serial_out_reg;
  logic tx_serial_valid_reg;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire a_take = hsel && hready && htrans[1];
  wire a_map = (haddr[31:`TSE_MAP_LSB] == '0);
  wire [4:0] a_idx = haddr[6:2];
  wire [7:0] wdat = hwdata[7:0];
  wire wr_pcd = wr_pend_reg && (wr_idx_reg[4:2] == `TSE_GRP_PCD);
  wire wr_ssie = wr_pend_reg && (wr_idx_reg[4:2] == `TSE_GRP_SSIE);
  wire wr_ts = wr_pend_reg && wr_idx_reg[4];
  wire wr_stat4 = wr_pend_reg && (wr_idx_reg == `TSE_IDX_STAT4);
  wire [7:0] rd_byte =
    !a_map ? `TSE_RST_BYTE :
    a_idx[4] ? ts_reg[a_idx[3:0]] :
    (a_idx[4:2] == `TSE_GRP_SSIE) ? ssie_reg[a_idx[1:0]] :
    (a_idx[4:2] == `TSE_GRP_PCD) ? pcd_reg[a_idx[1:0]] :
    (a_idx == `TSE_IDX_SIGCTL) ? sigctl_reg :
    (a_idx == `TSE_IDX_PCPTR) ? pcptr_reg :
    (a_idx == `TSE_IDX_T1TXC) ? t1txc_reg :
    (a_idx == `TSE_IDX_E1TXC) ? e1txc_reg :
    (a_idx == `TSE_IDX_STAT4) ? stat4_reg :
    (a_idx == `TSE_IDX_MODE) ? mode_reg :
    (a_idx == `TSE_IDX_FRZST) ? {5'h00, frz_state_reg} : `TSE_RST_BYTE;
  // A read straight after a write to the same register sees the new value, except a STAT4 bit set by tx_load in the write cycle
  wire fwd_hit = wr_pend_reg && a_map && (wr_idx_reg == a_idx) && (a_idx != `TSE_IDX_FRZST);
  wire [7:0] fwd_byte = (a_idx == `TSE_IDX_STAT4) ? (rd_byte & ~wdat) : wdat;
  wire [7:0] rd_final = fwd_hit ? fwd_byte : rd_byte;

  // ----------------------------------------------------------------------
  // Mode and control decode
  // ----------------------------------------------------------------------
  wire m_e1 = mode_reg[`TSE_BIT_E1];
  wire m_t1 = !m_e1;
  wire m_esf = mode_reg[`TSE_BIT_ESF];
  wire m_cas = mode_reg[`TSE_BIT_CAS];
  wire m_d4 = m_t1 && !m_esf;
  wire [31:0] pcd_flat = {pcd_reg[3], pcd_reg[2], pcd_reg[1], pcd_reg[0]};
  wire [31:0] ssie_flat = {ssie_reg[3], ssie_reg[2], ssie_reg[1], ssie_reg[0]};
  wire rein_sel = pcptr_reg[`TSE_BIT_REIN];
  wire ones_sel = pcptr_reg[`TSE_BIT_ONES];
  wire [4:0] mf_len = m_e1 ? `TSE_MF_E1 : (m_esf ? `TSE_MF_ESF : `TSE_MF_D4);
  wire [4:0] last_chan = m_e1 ? `TSE_E1_LAST : `TSE_T1_LAST;

  // ----------------------------------------------------------------------
  // Freeze control
  // ----------------------------------------------------------------------
  wire rx_err = rx_loss_of_frame || rx_carrier_loss || rx_frame_slip;
  wire frz_en = sigctl_reg[`TSE_BIT_FE];
  wire frz_force = sigctl_reg[`TSE_BIT_FF];
  wire [19:0] hold_load = (m_d4 ? 20'(HOLD_D4_CYC) : 20'(HOLD_ESF_CYC));
  wire freeze_on = frz_force || (frz_state_reg != tse_pkg::TSE_RUN);

  always_comb
  begin
    frz_state_next = frz_state_reg;
    hold_cnt_next = hold_cnt_reg;
    case (frz_state_reg)
      tse_pkg::TSE_RUN:
        if (frz_en && rx_err)
          frz_state_next = tse_pkg::TSE_FROZEN;
      tse_pkg::TSE_FROZEN:
        if (!frz_en)
          frz_state_next = tse_pkg::TSE_RUN;
        else if (!rx_err)
        begin
          frz_state_next = tse_pkg::TSE_HOLD;
          hold_cnt_next = hold_load;
        end
      tse_pkg::TSE_HOLD:
        if (!frz_en)
          frz_state_next = tse_pkg::TSE_RUN;
        else if (rx_err)
          frz_state_next = tse_pkg::TSE_FROZEN;
        else if (hold_cnt_reg == 20'h00000)
          frz_state_next = tse_pkg::TSE_RUN;
        else
          hold_cnt_next = hold_cnt_reg - 20'h00001;
      default:
        frz_state_next = tse_pkg::TSE_RUN;
    endcase
  end

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  wire rx_ts16 = m_e1 && (rx_chan_idx == `TSE_TS16);
  wire [4:0] rd_chan_a = rx_ts16 ? bp_frame_reg : rx_chan_idx;
  wire [4:0] rd_chan_b = bp_frame_reg + `TSE_TS16;
  logic [3:0] nib_a;
  logic [3:0] nib_b;

  // Writes and slot advance stop while frozen, so the oldest slot stays good
  tse_sig_buffer #(
    .CHANS(32),
    .DEPTH(4)
  ) u_buf (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(rx_sig_wr && !freeze_on),
    .wr_chan(rx_sig_chan),
    .wr_nib(rx_sig_nib),
    .mf_adv(rx_line_mf && !freeze_on),
    .rd_chan_a(rd_chan_a),
    .rd_chan_b(rd_chan_b),
    .rd_nib_a(nib_a),
    .rd_nib_b(nib_b)
  );

  // ----------------------------------------------------------------------
  // Receive reinsertion and force-ones
  // ----------------------------------------------------------------------
  wire sync_edge = sync_s2_reg && !sync_s3_reg;
  wire rx_frame_end = rx_chan_valid && (rx_chan_idx == last_chan);
  wire rx_chan_mark = pcd_flat[rx_chan_idx];
  wire rx_rob = m_t1 && is_rob(bp_frame_reg, m_esf);
  wire t1_rein = rein_sel && rx_chan_mark;
  wire t1_ones = ones_sel && rx_chan_mark;
  wire e1_rein = sigctl_reg[`TSE_BIT_GRE] || (rein_sel && rx_chan_mark);
  wire rob_bit = sel_bit(nib_a, bp_frame_reg, 1'b0);
  // Original robbed bits in other frames pass untouched
  wire [7:0] rx_t1_byte = {rx_chan_data[7:1],
                           t1_ones ? 1'b1 : (t1_rein ? rob_bit : rx_chan_data[0])};
  wire rx_e1_hit = rx_ts16 && e1_rein && (bp_frame_reg != 5'h00);
  wire [7:0] rx_byte = (rx_rob && m_t1) ? rx_t1_byte :
                       rx_e1_hit ? {nib_a, nib_b} : rx_chan_data;
  wire [7:0] sig_byte = m_d4 ? {4'h0, nib_a[3:2], nib_a[3:2]} : {4'h0, nib_a};

  // ----------------------------------------------------------------------
  // Transmit insertion
  // ----------------------------------------------------------------------
  wire tx_load = tx_mf_boundary && (!m_d4 || !d4_phase_reg);
  wire tx_lo = (tx_chan_idx >= `TSE_T1_HALF);
  // Index wraps below twelve, so registers 12..15 never reach a T1 line
  wire [4:0] tx_ridx = tx_lo ? (tx_chan_idx - `TSE_T1_HALF) : tx_chan_idx;
  wire [7:0] tx_t1_reg = shadow_reg[tx_ridx[3:0]];
  wire [3:0] tx_t1_nib = tx_lo ? tx_t1_reg[3:0] : tx_t1_reg[7:4];
  wire tx_t1_bit = sel_bit(tx_t1_nib, tx_frame_num, m_d4 && !d4_phase_reg);
  wire tx_t1_ins = m_t1 && t1txc_reg[`TSE_BIT_T1TXEN] && ssie_flat[tx_chan_idx] &&
                   (tx_chan_idx <= `TSE_T1_LAST) && is_rob(tx_frame_num, m_esf);
  wire tx_e1_ins = m_e1 && e1txc_reg[`TSE_BIT_E1TXEN] && (tx_chan_idx == `TSE_TS16) &&
                   ssie_flat[`TSE_TS16];
  // Frame 0 carries the CAS alignment byte from the first register
  wire [7:0] tx_e1_byte = m_cas ? shadow_reg[tx_frame_num[3:0]] : shadow_reg[0];
  wire [7:0] tx_byte = tx_t1_ins ? {tx_chan_data[7:1], tx_t1_bit} :
                       tx_e1_ins ? tx_e1_byte : tx_chan_data;

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_shadow
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          shadow_reg[g] <= `TSE_RST_BYTE;
        else if (tx_load)
          shadow_reg[g] <= ts_reg[g];
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 5'h00;
      hrdata_reg <= 32'h00000000;
      hreadyout_reg <= 1'b0;
      hresp_reg <= 1'b0;
    end
    else
    begin
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      wr_pend_reg <= a_take && hwrite && a_map;
      if (a_take)
        wr_idx_reg <= a_idx;
      if (a_take && !hwrite)
        hrdata_reg <= {24'h000000, rd_final};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sigctl_reg <= `TSE_RST_BYTE;
      pcptr_reg <= `TSE_RST_BYTE;
      t1txc_reg <= `TSE_RST_BYTE;
      e1txc_reg <= `TSE_RST_BYTE;
      mode_reg <= `TSE_RST_BYTE;
      pcd_reg <= '{default: `TSE_RST_BYTE};
      ssie_reg <= '{default: `TSE_RST_BYTE};
      ts_reg <= '{default: `TSE_RST_BYTE};
    end
    else if (wr_pend_reg)
    begin
      if (wr_idx_reg == `TSE_IDX_SIGCTL)
        sigctl_reg <= wdat;
      if (wr_idx_reg == `TSE_IDX_PCPTR)
        pcptr_reg <= wdat;
      if (wr_idx_reg == `TSE_IDX_T1TXC)
        t1txc_reg <= wdat;
      if (wr_idx_reg == `TSE_IDX_E1TXC)
        e1txc_reg <= wdat;
      if (wr_idx_reg == `TSE_IDX_MODE)
        mode_reg <= wdat;
      if (wr_pcd)
        pcd_reg[wr_idx_reg[1:0]] <= wdat;
      if (wr_ssie)
        ssie_reg[wr_idx_reg[1:0]] <= wdat;
      if (wr_ts)
        ts_reg[wr_idx_reg[3:0]] <= wdat;
    end
  end

  // Set beats a simultaneous write-one-to-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat4_reg <= `TSE_RST_BYTE;
    else
      stat4_reg[`TSE_BIT_TXMF] <= tx_load ||
        (stat4_reg[`TSE_BIT_TXMF] && !(wr_stat4 && wdat[`TSE_BIT_TXMF]));
  end

  // ----------------------------------------------------------------------
  // Stream and freeze state
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
      bp_frame_reg <= 5'h00;
      d4_phase_reg <= 1'b0;
      frz_state_reg <= tse_pkg::TSE_RUN;
      hold_cnt_reg <= 20'h00000;
    end
    else
    begin
      sync_s1_reg <= rx_multiframe_sync_pin;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
      if (sync_edge)
        bp_frame_reg <= 5'h00;
      else if (rx_frame_end)
        bp_frame_reg <= (bp_frame_reg == mf_len - 5'h01) ? 5'h00 : bp_frame_reg + 5'h01;
      if (tx_mf_boundary)
        d4_phase_reg <= m_d4 ? !d4_phase_reg : 1'b0;
      frz_state_reg <= frz_state_next;
      hold_cnt_reg <= hold_cnt_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_serial_out_reg <= 8'h00;
      rx_serial_valid_reg <= 1'b0;
      rx_signaling_out_reg <= 8'h00;
      rx_freeze_reg <= 1'b0;
      tx_serial_out_reg <= 8'h00;
      tx_serial_valid_reg <= 1'b0;
    end
    else
    begin
      rx_freeze_reg <= freeze_on;
      rx_serial_valid_reg <= rx_chan_valid;
      tx_serial_valid_reg <= tx_chan_valid;
      if (rx_chan_valid)
      begin
        rx_serial_out_reg <= rx_byte;
        rx_signaling_out_reg <= sig_byte;
      end
      if (tx_chan_valid)
        tx_serial_out_reg <= tx_byte;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign rx_serial_out = rx_serial_out_reg;
  assign rx_serial_valid = rx_serial_valid_reg;
  assign rx_signaling_out = rx_signaling_out_reg;
  assign rx_freeze_indicator = rx_freeze_reg;
  assign tx_serial_out = tx_serial_out_reg;
  assign tx_serial_valid = tx_serial_valid_reg;
endmodule : tse_signaling

`default_nettype wire

// file: tse_params.svh
/*
  Constants for the T1/E1 signaling insert/extract block: register indices,
  bit positions, reset values, frame counts and hold-off times.
  Assumes it is included by every file that needs one of these names.
*/
`ifndef TSE_PARAMS_SVH
`define TSE_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TSE_CLK_MHZ 100
`define TSE_HOLD_ESF_US 9000
`define TSE_HOLD_D4_US 4500

// ----------------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------------
`define TSE_IDX_SIGCTL 5'h00
`define TSE_IDX_PCPTR 5'h01
`define TSE_IDX_T1TXC 5'h02
`define TSE_IDX_E1TXC 5'h03
`define TSE_IDX_STAT4 5'h04
`define TSE_IDX_MODE 5'h05
`define TSE_IDX_FRZST 5'h06
`define TSE_GRP_PCD 3'h2
`define TSE_GRP_SSIE 3'h3
`define TSE_MAP_LSB 7

// ----------------------------------------------------------------------
// Bit positions and reset values
// ----------------------------------------------------------------------
`define TSE_BIT_GRE 7
`define TSE_BIT_FE 4
`define TSE_BIT_FF 3
`define TSE_BIT_REIN 0
`define TSE_BIT_ONES 1
`define TSE_BIT_T1TXEN 4
`define TSE_BIT_E1TXEN 6
`define TSE_BIT_TXMF 4
`define TSE_BIT_E1 0
`define TSE_BIT_ESF 1
`define TSE_BIT_CAS 2
`define TSE_RST_BYTE 8'h00

// ----------------------------------------------------------------------
// Frame and channel numbers
// ----------------------------------------------------------------------
`define TSE_MF_ESF 5'h18
`define TSE_MF_D4 5'h0C
`define TSE_MF_E1 5'h10
`define TSE_ROB_A 5'h05
`define TSE_ROB_B 5'h0B
`define TSE_ROB_C 5'h11
`define TSE_ROB_D 5'h17
`define TSE_TS16 5'h10
`define TSE_T1_LAST 5'h17
`define TSE_E1_LAST 5'h1F
`define TSE_T1_HALF 5'h0C

`endif

// file: tse_pkg.sv
/*
  Types shared by the signaling block.
  Assumes tse_params.svh supplies the numeric constants.
*/
`default_nettype none

package tse_pkg;
  typedef enum logic [2:0] {
    TSE_RUN = 3'b001,
    TSE_FROZEN = 3'b010,
    TSE_HOLD = 3'b100
  } tse_frz_state_t;
  typedef logic [7:0] tse_byte_t;
endpackage : tse_pkg

`default_nettype wire

// file: tse_sig_buffer.sv
/*
  Receive signaling buffer: DEPTH multiframes of CHANS nibbles in flip-flops.
  Assumes the caller gates writes and slot advance while frozen.
*/
`default_nettype none

module tse_sig_buffer #(
  parameter int CHANS = 32,
  parameter int DEPTH = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [4:0] wr_chan,
  input wire logic [3:0] wr_nib,
  input wire logic mf_adv,
  input wire logic [4:0] rd_chan_a,
  input wire logic [4:0] rd_chan_b,
  output logic [3:0] rd_nib_a,
  output logic [3:0] rd_nib_b
);
  localparam int SW = $clog2(DEPTH);
  localparam int AW = SW + 5;

  logic [SW-1:0] wr_slot_reg;
  logic [SW-1:0] rd_slot;
  logic [3:0] mem_reg [DEPTH*CHANS];

  // Oldest complete slot: DEPTH-1 multiframes behind the one being filled
  assign rd_slot = wr_slot_reg - SW'(DEPTH - 1);
  assign rd_nib_a = mem_reg[{rd_slot, rd_chan_a}];
  assign rd_nib_b = mem_reg[{rd_slot, rd_chan_b}];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_slot_reg <= '0;
    else if (mf_adv)
      wr_slot_reg <= wr_slot_reg + SW'(1);
  end

  genvar g;
  generate
    for (g = 0; g < DEPTH * CHANS; g++)
    begin : g_ent
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          mem_reg[g] <= 4'h0;
        else if (wr_en && ({wr_slot_reg, wr_chan} == AW'(g)))
          mem_reg[g] <= wr_nib;
      end
    end
  endgenerate
endmodule : tse_sig_buffer

`default_nettype wire

// file: tse_sig_chk.sv
/*
  Port checker for the signaling block, bound into tse_signaling.
  Assumes a single hclk domain and the one-cycle stream latency.
*/
`include "tse_params.svh"
`default_nettype none

module tse_sig_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_chan_valid,
  input wire logic rx_serial_valid,
  input wire logic [7:0] rx_serial_out,
  input wire logic [7:0] rx_signaling_out,
  input wire logic rx_freeze_indicator,
  input wire logic rx_loss_of_frame,
  input wire logic rx_carrier_loss,
  input wire logic rx_frame_slip,
  input wire logic tx_chan_valid,
  input wire logic [4:0] tx_chan_idx,
  input wire logic [4:0] tx_frame_num,
  input wire logic [7:0] tx_chan_data,
  input wire logic [7:0] tx_serial_out,
  input wire logic tx_serial_valid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic err;
  assign err = rx_loss_of_frame | rx_carrier_loss | rx_frame_slip;

  rx_valid_a: assert property (rx_chan_valid |=> rx_serial_valid) else $error("rx valid missing");
  rx_idle_a: assert property (!rx_chan_valid |=> !rx_serial_valid && $stable(rx_serial_out))
    else $error("rx output moved without a strobe");
  tx_valid_a: assert property (tx_chan_valid |=> tx_serial_valid) else $error("tx valid missing");
  tx_idle_a: assert property (!tx_chan_valid |=> !tx_serial_valid && $stable(tx_serial_out))
    else $error("tx output moved without a strobe");
  tx_pass_a: assert property (tx_chan_valid && tx_chan_idx != `TSE_TS16
    && !(tx_frame_num inside {`TSE_ROB_A, `TSE_ROB_B, `TSE_ROB_C, `TSE_ROB_D})
    |=> tx_serial_out == $past(tx_chan_data)) else $error("tx byte altered outside signaling slot");
  sig_nibble_a: assert property (rx_serial_valid |-> rx_signaling_out[7:4] == 4'h0)
    else $error("signaling upper nibble set");
  hold_time_a: assert property ($fell(err) && rx_freeze_indicator |=> rx_freeze_indicator [*8])
    else $error("freeze released too early");
  frz_clear_a: assert property ($fell(rx_freeze_indicator) |-> !err && !$past(err))
    else $error("freeze released during error");
endmodule : tse_sig_chk

bind tse_signaling tse_sig_chk i_chk (.hclk, .hresetn, .rx_chan_valid, .rx_serial_valid, .rx_serial_out,
  .rx_signaling_out, .rx_freeze_indicator, .rx_loss_of_frame, .rx_carrier_loss, .rx_frame_slip,
  .tx_chan_valid, .tx_chan_idx, .tx_frame_num, .tx_chan_data, .tx_serial_out, .tx_serial_valid);

`default_nettype wire

// file: tse_bp_model.sv
/*
  Backplane stand-in: one sync pulse, then receive channel strobes.
  Assumes run is raised once the mode is set; the pin stays low afterwards.
*/
`default_nettype none

module tse_bp_model #(
  parameter int FRAMES = 24
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic sync_pin,
  output logic line_mf,
  output logic valid,
  output logic [4:0] chn,
  output logic [4:0] lchn,
  output logic [4:0] lfrm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] st;
  logic [4:0] frm;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {st, sync_pin, line_mf, valid, chn, lchn, frm, lfrm} <= '0;
    else if (run && st != 3'h4)
    begin
      st <= st + 3'h1;
      sync_pin <= (st == 3'h0);
    end
    else if (run)
    begin
      // Strobe every other cycle, as an elastic store on a slow backplane would
      valid <= !valid;
      line_mf <= valid && chn == 5'h17 && frm == 5'(FRAMES - 1);
      if (valid)
      begin
        lchn <= chn;
        lfrm <= frm;
        chn <= (chn == 5'h17) ? 5'h00 : chn + 5'h01;
        if (chn == 5'h17)
          frm <= (frm == 5'(FRAMES - 1)) ? 5'h00 : frm + 5'h01;
      end
    end
  end
endmodule : tse_bp_model

`default_nettype wire

// file: tb.sv
/*
  Self-checking bench: registers, freeze, transmit insertion, force-ones.
  Assumes a zero-wait AHB-Lite slave and the backplane model.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, run = 0, tx_mf_boundary = 0, tx_chan_valid = 0;
  logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
  logic [2:0] hsize = 3'h2, err3 = 3'h0;
  logic [1:0] htrans = 2'h0;
  logic [4:0] tx_chan_idx = '0, tx_frame_num = '0, rx_sig_chan = '0, chn, lchn, lfrm;
  logic [7:0] tx_chan_data = '0, rx_chan_data = '0, rx_serial_out, rx_signaling_out, tx_serial_out;
  logic [3:0] rx_sig_nib = '0;
  logic rx_sig_wr = 0;
  logic hready, hreadyout, hresp, rx_serial_valid, rx_freeze_indicator, tx_serial_valid, sync_pin, line_mf, m_valid;
  logic rx_loss_of_frame, rx_carrier_loss, rx_frame_slip;
  int bad_count = 0, total_checks = 0, cyc = 0, mfc = 0;
  assign hready = hreadyout;
  assign {rx_frame_slip, rx_carrier_loss, rx_loss_of_frame} = err3;
  always #5 hclk = ~hclk;

  tse_signaling #(.HOLD_ESF_CYC(20), .HOLD_D4_CYC(10)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_multiframe_sync_pin(sync_pin), .rx_line_mf(line_mf),
    .rx_sig_wr, .rx_sig_chan, .rx_sig_nib, .rx_loss_of_frame, .rx_carrier_loss, .rx_frame_slip,
    .rx_chan_valid(m_valid), .rx_chan_idx(chn), .rx_chan_data, .rx_serial_out, .rx_serial_valid,
    .rx_signaling_out, .rx_freeze_indicator, .tx_mf_boundary, .tx_chan_valid, .tx_chan_idx, .tx_frame_num,
    .tx_chan_data, .tx_serial_out, .tx_serial_valid);
  tse_bp_model #(.FRAMES(24)) i_bp (.clk(hclk), .rst_n(hresetn), .run, .sync_pin, .line_mf, .valid(m_valid),
    .chn, .lchn, .lfrm);

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hsize <= 3'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task rdc(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk("register", e, rd);
  endtask : rdc

  task txc(input logic [4:0] c, input logic [4:0] f, input logic [7:0] d, input logic [7:0] e);
    @(posedge hclk);
    tx_chan_valid <= 1'b1;
    tx_chan_idx <= c;
    tx_frame_num <= f;
    tx_chan_data <= d;
    @(posedge hclk);
    tx_chan_valid <= 1'b0;
    @(negedge hclk);
    chk("tx byte", {24'h0, e}, {24'h0, tx_serial_out});
  endtask : txc

  task pulse_mf;
    @(posedge hclk);
    tx_mf_boundary <= 1'b1;
    @(posedge hclk);
    tx_mf_boundary <= 1'b0;
  endtask : pulse_mf

  task t_regs;
    ahb(1'b1, 32'h18, 32'hFF);
    rdc(32'h18, 32'h01);
    ahb(1'b1, 32'h00, 32'h80);
    rdc(32'h00, 32'h80);
    rdc(32'h80, 32'h00);
    ahb(1'b1, 32'h00, 32'h00);
    $display("registers test done");
  endtask : t_regs

  task t_freeze;
    ahb(1'b1, 32'h00, 32'h10);
    // Each error source in turn; D4 hold is 10 cycles here
    for (int k = 0; k < 3; k++)
    begin
      @(posedge hclk);
      err3 <= 3'h1 << k;
      repeat (4) @(negedge hclk);
      chk("freeze pin", 32'h1, {31'h0, rx_freeze_indicator});
      rdc(32'h18, 32'h02);
      err3 <= 3'h0;
      repeat (5) @(negedge hclk);
      chk("freeze pin", 32'h1, {31'h0, rx_freeze_indicator});
      repeat (20) @(negedge hclk);
      chk("freeze pin", 32'h0, {31'h0, rx_freeze_indicator});
    end
    ahb(1'b1, 32'h00, 32'h08);
    repeat (3) @(negedge hclk);
    chk("freeze pin", 32'h1, {31'h0, rx_freeze_indicator});
    ahb(1'b1, 32'h00, 32'h00);
    repeat (40) @(posedge hclk);
    $display("freeze test done");
  endtask : t_freeze

  task t_tx;
    ahb(1'b1, 32'h14, 32'h02);
    ahb(1'b1, 32'h08, 32'h10);
    ahb(1'b1, 32'h30, 32'h01);
    ahb(1'b1, 32'h40, 32'hA0);
    pulse_mf();
    rdc(32'h10, 32'h10);
    ahb(1'b1, 32'h10, 32'h10);
    rdc(32'h10, 32'h00);
    txc(5'h00, 5'h05, 8'h00, 8'h01);
    txc(5'h00, 5'h0B, 8'h01, 8'h00);
    txc(5'h00, 5'h11, 8'h00, 8'h01);
    txc(5'h00, 5'h00, 8'h5A, 8'h5A);
    txc(5'h01, 5'h05, 8'h00, 8'h00);
    ahb(1'b1, 32'h40, 32'h50);
    pulse_mf();
    txc(5'h00, 5'h05, 8'h01, 8'h00);
    // D4: load, then a write after the load boundary must wait for the next load
    ahb(1'b1, 32'h14, 32'h00);
    ahb(1'b1, 32'h40, 32'h20);
    pulse_mf();
    ahb(1'b1, 32'h40, 32'h00);
    txc(5'h00, 5'h05, 8'h01, 8'h00);
    pulse_mf();
    txc(5'h00, 5'h05, 8'h00, 8'h01);
    ahb(1'b1, 32'h08, 32'h00);
    txc(5'h00, 5'h05, 8'h00, 8'h00);
    $display("transmit test done");
  endtask : t_tx

  task t_rx;
    ahb(1'b1, 32'h14, 32'h02);
    ahb(1'b1, 32'h04, 32'h02);
    ahb(1'b1, 32'h20, 32'h01);
    // Channel 1 nibble goes into the slot that is read three multiframes later
    @(posedge hclk);
    rx_sig_wr <= 1'b1;
    rx_sig_chan <= 5'h01;
    rx_sig_nib <= 4'h8;
    rx_chan_data <= 8'hFE;
    @(posedge hclk);
    rx_sig_wr <= 1'b0;
    run <= 1'b1;
    repeat (700) @(negedge hclk)
      if (rx_serial_valid === 1'b1 && (lfrm == 5'h05 || lfrm == 5'h0B) && lchn < 5'h02)
        chk("robbed bit", {31'h0, lchn == 5'h00}, {31'h0, rx_serial_out[0]});
    ahb(1'b1, 32'h04, 32'h01);
    ahb(1'b1, 32'h20, 32'h02);
    while (mfc < 4)
    begin
      @(negedge hclk);
      if (line_mf === 1'b1)
        mfc++;
      if (mfc == 3 && rx_serial_valid === 1'b1 && lchn == 5'h01 && (lfrm == 5'h05 || lfrm == 5'h0B))
      begin
        chk("reinserted byte", {24'h0, 8'hFE | 8'(lfrm == 5'h05)}, {24'h0, rx_serial_out});
        chk("signaling out", 32'h08, {24'h0, rx_signaling_out});
      end
    end
    $display("receive test done");
  endtask : t_rx

  task end_sim;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_freeze();
    t_tx();
    t_rx();
    end_sim();
  end
endmodule : tb

`default_nettype wire
